// ---- hdl/emp_fmt_decode.sv ----
`default_nettype none
module emp_fmt_decode (
  // Format controls.
  input wire logic bus_width_sel_i,
  input wire logic [2:0] word_length_sel_i,
  input wire logic [3:0] addressing_mode_sel_i,
  // Derived counts.
  output logic [2:0] accesses_o,
  output logic [3:0] locations_o,
  output logic [4:0] data_bits_o,
  output logic relative_o,
  output logic dynamic_o,
  output logic format_ok_o
);
  // Per word length: bits moved, accesses and locations.
  always_comb begin
    data_bits_o = 5'd24;
    format_ok_o = 1'b1;
    accesses_o = 3'd6;
    locations_o = 4'd8;
    case (word_length_sel_i)
      emp_pkg::WL_8: begin
        data_bits_o = 5'd8;
        accesses_o = bus_width_sel_i ? 3'd1 : 3'd2;
        locations_o = bus_width_sel_i ? 4'd1 : 4'd2;
      end
      emp_pkg::WL_12: begin
        // RULE6 eight-bit rounding
        data_bits_o = bus_width_sel_i ? 5'd16 : 5'd12;
        accesses_o = bus_width_sel_i ? 3'd2 : 3'd3;
        locations_o = bus_width_sel_i ? 4'd2 : 4'd4;
      end
      emp_pkg::WL_16: begin
        data_bits_o = 5'd16;
        accesses_o = bus_width_sel_i ? 3'd2 : 3'd4;
        locations_o = bus_width_sel_i ? 4'd2 : 4'd4;
      end
      emp_pkg::WL_16A24: begin
        // RULE10 wide address accesses
        data_bits_o = 5'd16;
        accesses_o = bus_width_sel_i ? 3'd2 : 3'd4;
        locations_o = bus_width_sel_i ? 4'd4 : 4'd8;
      end
      emp_pkg::WL_20: begin
        // RULE6 eight-bit rounding
        data_bits_o = bus_width_sel_i ? 5'd24 : 5'd20;
        accesses_o = bus_width_sel_i ? 3'd3 : 3'd5;
        locations_o = bus_width_sel_i ? 4'd4 : 4'd8;
      end
      emp_pkg::WL_24: begin
        accesses_o = bus_width_sel_i ? 3'd3 : 3'd6;
        locations_o = bus_width_sel_i ? 4'd4 : 4'd8;
      end
      default: begin
        format_ok_o = 1'b0;
      end
    endcase
    // RULE15 mode type
    relative_o = (addressing_mode_sel_i[3:2] == 2'b01) ||
                 ((addressing_mode_sel_i[3:2] == 2'b00) &&
                  (addressing_mode_sel_i != emp_pkg::AM_ABS_SRAM));
    dynamic_o = addressing_mode_sel_i[2];
    if (addressing_mode_sel_i[3:2] == 2'b10) begin
      format_ok_o = 1'b0;
    end
    // RULE11 absolute locations
    if (!relative_o) begin
      locations_o = {1'b0, accesses_o};
    end
  end
endmodule : emp_fmt_decode
`default_nettype wire

// ---- hdl/emp_word_pack.sv ----
`default_nettype none
//Behaviour
//RULE1: Packing and unpacking take place in a 24-bit internal staging buffer.
//RULE2: 8- and 16-bit stores send only the buffer's upper bits.
//RULE3: 8- and 16-bit fetches are top aligned with zero fill.
//RULE4: 4-bit bus stores of 12/20-bit words send only the upper bits.
//RULE5: 4-bit bus fetches of 12/20-bit words are top aligned, zero filled.
//RULE6: 8-bit bus moves 12-bit words as 16, 20-bit as 24.
//RULE7: Writes copy write data into the buffer; buffer is not software visible.
//RULE8: Software leaves control bits alone while busy, except interrupt and trigger.
//RULE9: Control bit 0 selects 4- or 8-bit bus; reset clears it.
//RULE10: Accesses per word follow bus width and word length.
//RULE11: Relative words use power-of-two blocks; absolute locations equal accesses.
//RULE12: Bits 16,2,1 encode word length; reset clears them.
//RULE13: Bits 6 to 3 select addressing mode; reset clears them.
//RULE14: Static modes set address line count and chip select use.
//RULE15: Dynamic modes use 8 to 11 multiplexed lines; 10xx reserved.
//RULE16: Absolute static mode holds select 0 and address line 15 high.
//RULE17: Absolute modes with post-increment bump the base after each access.
//RULE18: The 16/24 format has 16-bit capacity in absolute modes.
//RULE19: Relative address is base minus read or write offset.
//RULE20: Most significant segment goes first at the lowest location.
//RULE21: Dynamic modes use one 4-bit device, or two on 8-bit bus.
module emp_word_pack (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic soft_reset_i,
  // Control register port.
  input wire logic csr_we_i,
  input wire logic [23:0] csr_wdata_i,
  output logic [23:0] memif_control_status_o,
  // Transfer requests.
  input wire logic write_start_i,
  input wire logic [23:0] write_data_reg_i,
  input wire logic read_start_i,
  input wire logic [23:0] delay_base_reg_i,
  input wire logic [23:0] offset_i,
  input wire logic incr_en_i,
  // Word results.
  output logic [23:0] read_data_reg_o,
  output logic read_done_o,
  output logic write_done_o,
  output logic base_incr_o,
  // External memory pins.
  output logic [17:0] mem_addr_lines_o,
  output logic [3:0] mem_selects_o,
  output logic [7:0] mem_data_o,
  output logic mem_data_oe_o,
  output logic mem_strobe_o,
  input wire logic [7:0] mem_data_i
);
  logic [23:0] csr_ff;
  logic [23:0] pack_staging_buffer_ff;
  logic [3:0] seg_ff;
  logic [23:0] addr_ff;
  emp_pkg::emp_state_t state_ff;
  logic [7:0] din_s1_ff;
  logic [7:0] din_s2_ff;
  logic [17:0] ma_ff;
  logic [3:0] mcs_ff;
  logic [7:0] mdo_ff;
  logic oe_ff;
  logic stb_ff;
  logic [23:0] rdata_ff;
  logic rdone_ff;
  logic wdone_ff;
  logic incr_ff;
  logic [2:0] accesses;
  logic [3:0] locations;
  logic [4:0] data_bits;
  logic relative;
  logic dynamic;
  logic format_ok;
  logic bus8;
  logic [3:0] amode;
  logic [23:0] loc_addr;
  logic [23:0] word_mask;
  logic [23:0] seg_mask;
  logic [7:0] seg_out;
  logic [23:0] merged;
  logic last_seg;
  logic rd_last;
  logic issuing;
  logic [3:0] pseg;
  logic [3:0] rseg;

  assign bus8 = csr_ff[emp_pkg::BW_BIT];
  assign amode = csr_ff[emp_pkg::AM_HI:emp_pkg::AM_LO];

  emp_fmt_decode u_decode (
    .bus_width_sel_i(bus8),
    .word_length_sel_i({csr_ff[emp_pkg::WL2_BIT], csr_ff[emp_pkg::WL1_BIT],
                        csr_ff[emp_pkg::WL0_BIT]}),
    .addressing_mode_sel_i(amode),
    .accesses_o(accesses),
    .locations_o(locations),
    .data_bits_o(data_bits),
    .relative_o(relative),
    .dynamic_o(dynamic),
    .format_ok_o(format_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control register; busy bit reflects the engine.
  // RULE9 reset clears bits
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      csr_ff <= emp_pkg::CSR_RESET;
    end else if (soft_reset_i) begin
      csr_ff <= emp_pkg::CSR_RESET;
    end else begin
      // RULE12 word length field
      // RULE13 mode field
      if (csr_we_i) begin
        csr_ff <= csr_wdata_i & emp_pkg::CSR_WMASK;
      end
      csr_ff[emp_pkg::BUSY_BIT] <= (state_ff != emp_pkg::EMP_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input data pins pass two flip-flops before use.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      din_s1_ff <= 8'h00;
      din_s2_ff <= 8'h00;
    end else begin
      din_s1_ff <= mem_data_i;
      din_s2_ff <= din_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine step flags. Pins are driven for the word's accesses only; a read
  // then keeps stepping until its last byte has left the synchroniser, so
  // the segment being merged trails the segment being issued.
  always_comb begin
    issuing = (state_ff != emp_pkg::EMP_IDLE) && (seg_ff < {1'b0, accesses});
    last_seg = (seg_ff == {1'b0, accesses} - 4'd1);
    rd_last = (seg_ff == {1'b0, accesses} + emp_pkg::RD_LAG - 4'd1);
    pseg = issuing ? seg_ff : 4'h0;
    rseg = seg_ff - emp_pkg::RD_LAG;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment selection, top of the buffer first.
  always_comb begin
    word_mask = 24'hffffff << (5'd24 - data_bits);
    // RULE20 msb first
    if (bus8) begin
      seg_out = pack_staging_buffer_ff[23 - 8 * pseg -: 8];
      seg_mask = 24'hff0000 >> (8 * rseg);
    end else begin
      seg_out = {4'h0, pack_staging_buffer_ff[23 - 4 * pseg -: 4]};
      seg_mask = 24'hf00000 >> (4 * rseg);
    end
    // RULE3 zero fill below
    // RULE5 nibble zero fill
    // A byte reaches the synchroniser output a fixed lag after its address
    // went out, so it belongs to the segment issued that many steps before.
    // Merging by the issue count would store bytes of the wrong segment.
    if (bus8) begin
      merged = (pack_staging_buffer_ff & ~seg_mask) |
               ({din_s2_ff, 16'h0000} >> (8 * rseg));
    end else begin
      merged = (pack_staging_buffer_ff & ~seg_mask) |
               ({din_s2_ff[3:0], 20'h00000} >> (4 * rseg));
    end
    merged = merged & word_mask;
    // RULE18 capacity via location count
    if (relative) begin
      loc_addr = addr_ff * {20'h00000, locations} +
                 ((locations == 4'd1) ? 24'h0 : {20'h00000, seg_ff});
    end else begin
      loc_addr = addr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word engine: one bus access per cycle.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= emp_pkg::EMP_IDLE;
      seg_ff <= 4'h0;
      addr_ff <= 24'h000000;
      pack_staging_buffer_ff <= 24'h000000;
    end else if (soft_reset_i) begin
      state_ff <= emp_pkg::EMP_IDLE;
      seg_ff <= 4'h0;
    end else begin
      case (state_ff)
        emp_pkg::EMP_IDLE: begin
          seg_ff <= 4'h0;
          // RULE19 base minus offset
          addr_ff <= relative ? delay_base_reg_i - offset_i : delay_base_reg_i;
          if (write_start_i && format_ok) begin
            // RULE7 copy into buffer
            // RULE2 upper bits only
            // RULE4 nibble upper bits
            pack_staging_buffer_ff <= write_data_reg_i;
            state_ff <= emp_pkg::EMP_WRITE;
          end else if (read_start_i && format_ok) begin
            pack_staging_buffer_ff <= 24'h000000;
            state_ff <= emp_pkg::EMP_READ;
          end
        end
        emp_pkg::EMP_WRITE, emp_pkg::EMP_READ: begin
          // RULE1 hold in buffer
          // Reads count on through the synchroniser lag before the word is final.
          if ((state_ff == emp_pkg::EMP_READ) && (seg_ff >= emp_pkg::RD_LAG)) begin
            pack_staging_buffer_ff <= merged;
          end
          // RULE17 per access increment
          if (issuing && !relative && incr_en_i) begin
            addr_ff <= addr_ff + 24'h000001;
          end
          seg_ff <= seg_ff + 4'h1;
          if ((state_ff == emp_pkg::EMP_WRITE) ? last_seg : rd_last) begin
            state_ff <= emp_pkg::EMP_IDLE;
          end
        end
        default: begin
          state_ff <= emp_pkg::EMP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive. Strobe and data enable rise only for issued accesses, so the
  // read tail that waits on the synchroniser leaves the bus released.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ma_ff <= 18'h00000;
      mcs_ff <= 4'h0;
      mdo_ff <= 8'h00;
      oe_ff <= 1'b0;
      stb_ff <= 1'b0;
    end else begin
      stb_ff <= issuing;
      oe_ff <= issuing && (state_ff == emp_pkg::EMP_WRITE);
      mdo_ff <= seg_out;
      // RULE14 static pin use
      // RULE16 absolute static mode
      // RULE21 dynamic device mapping
      case (amode)
        emp_pkg::AM_ABS_SRAM: begin
          ma_ff <= {3'b001, loc_addr[14:0]};
          mcs_ff <= 4'h1;
        end
        emp_pkg::AM_SRAM1: begin
          ma_ff <= loc_addr[17:0];
          mcs_ff <= 4'h1;
        end
        emp_pkg::AM_SRAM2: begin
          ma_ff <= {1'b0, loc_addr[16:0]};
          mcs_ff <= 4'h1 << loc_addr[17];
        end
        emp_pkg::AM_SRAM4: begin
          ma_ff <= {3'b000, loc_addr[14:0]};
          mcs_ff <= 4'h1 << loc_addr[16:15];
        end
        default: begin
          ma_ff <= dynamic ? (loc_addr[17:0] & ~(18'h3ffff << (4'd8 + amode[1:0])))
                           : 18'h00000;
          mcs_ff <= 4'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion pulses, the finished read word and the base bump request.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= 24'h000000;
      rdone_ff <= 1'b0;
      wdone_ff <= 1'b0;
      incr_ff <= 1'b0;
    end else begin
      rdone_ff <= (state_ff == emp_pkg::EMP_READ) && rd_last;
      wdone_ff <= (state_ff == emp_pkg::EMP_WRITE) && last_seg;
      // RULE17 bump per access
      incr_ff <= issuing && incr_en_i && (!relative || last_seg);
      if ((state_ff == emp_pkg::EMP_READ) && rd_last) begin
        rdata_ff <= merged;
      end
    end
  end

  assign memif_control_status_o = csr_ff;
  assign read_data_reg_o = rdata_ff;
  assign read_done_o = rdone_ff;
  assign write_done_o = wdone_ff;
  assign base_incr_o = incr_ff;
  assign mem_addr_lines_o = ma_ff;
  assign mem_selects_o = mcs_ff;
  assign mem_data_o = mdo_ff;
  assign mem_data_oe_o = oe_ff;
  assign mem_strobe_o = stb_ff;
endmodule : emp_word_pack
`default_nettype wire

// ---- shared/emp_pkg.sv ----
`default_nettype none
package emp_pkg;
  // Control/status register field positions.
  localparam int BW_BIT = 0;
  localparam int WL0_BIT = 1;
  localparam int WL1_BIT = 2;
  localparam int AM_LO = 3;
  localparam int AM_HI = 6;
  localparam int BUSY_BIT = 15;
  localparam int WL2_BIT = 16;
  localparam int RTS_BIT = 17;
  localparam int CSR_W = 24;
  localparam logic [23:0] CSR_RESET = 24'h000000;
  localparam logic [23:0] CSR_WMASK = 24'h030e7f;
  // Word length codes.
  localparam logic [2:0] WL_8 = 3'h0;
  localparam logic [2:0] WL_16 = 3'h1;
  localparam logic [2:0] WL_24 = 3'h2;
  localparam logic [2:0] WL_16A24 = 3'h3;
  localparam logic [2:0] WL_12 = 3'h5;
  localparam logic [2:0] WL_20 = 3'h6;
  // Addressing mode codes.
  localparam logic [3:0] AM_ABS_SRAM = 4'h0;
  localparam logic [3:0] AM_SRAM1 = 4'h1;
  localparam logic [3:0] AM_SRAM2 = 4'h2;
  localparam logic [3:0] AM_SRAM4 = 4'h3;
  // Address widths of the static modes and the base address width of the dynamic modes.
  localparam int SRAM1_AW = 18;
  localparam int SRAM2_AW = 17;
  localparam int SRAM4_AW = 15;
  localparam int DRAM_AW_BASE = 8;
  // Word and address widths.
  localparam int WORD_W = 24;
  localparam int ADDR_W = 24;
  localparam int MA_W = 18;
  localparam int NIB_W = 4;
  localparam int BYTE_W = 8;
  // Cycles from the engine issuing an address to its byte at the synchroniser output.
  localparam logic [3:0] RD_LAG = 4'h3;
  // Engine states.
  typedef enum logic [1:0] {
    EMP_IDLE = 2'b00,
    EMP_WRITE = 2'b01,
    EMP_READ = 2'b10
  } emp_state_t;
endpackage : emp_pkg
`default_nettype wire

// ---- verification/emp_mem_model.sv ----
`default_nettype none
module emp_mem_model #(
  parameter int HOLD = 3
) (
  // Pins seen from the memory side.
  input wire logic clk_i,
  input wire logic [17:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic oe_i,
  input wire logic strobe_i,
  // Data returned to the block.
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  int hold = 0;
  // Stores write strobes and keeps each read byte for the hold time.
  always @(posedge clk_i) begin
    if (strobe_i && oe_i) begin
      mem[addr_i[7:0]] <= wdata_i;
    end
    if (strobe_i && !oe_i) begin
      last <= mem[addr_i[7:0]];
      hold <= HOLD;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  // Once the hold time after the last read strobe has run out the bus shows the inverse of the last byte.
  assign rdata_o = (strobe_i && !oe_i) ? mem[addr_i[7:0]] : (hold > 0) ? last : ~last;
endmodule : emp_mem_model
`default_nettype wire

// ---- verification/emp_word_pack_asserts.sv ----
`default_nettype none
module emp_word_pack_asserts (
  // Clock, reset and control.
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic soft_reset_i,
  input wire logic csr_we_i,
  input wire logic [23:0] csr_wdata_i,
  input wire logic [23:0] memif_control_status_o,
  input wire logic write_start_i,
  input wire logic read_start_i,
  // Results and pins.
  input wire logic [23:0] read_data_reg_o,
  input wire logic read_done_o,
  input wire logic write_done_o,
  input wire logic [17:0] mem_addr_lines_o,
  input wire logic [3:0] mem_selects_o,
  input wire logic mem_data_oe_o,
  input wire logic mem_strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bw;
  logic [2:0] wl;
  logic [7:0] nacc;
  logic [23:0] low;
  logic [7:0] cnt_ff;
  // Accesses per word and the low bits that must read back as zero.
  assign bw = memif_control_status_o[0];
  assign wl = {memif_control_status_o[16], memif_control_status_o[2:1]};
  assign nacc = (wl == 3'h0) ? (bw ? 8'h01 : 8'h02) : (wl == 3'h2) ? (bw ? 8'h03 : 8'h06) :
    (wl == 3'h5) ? (bw ? 8'h02 : 8'h03) : (wl == 3'h6) ? (bw ? 8'h03 : 8'h05) : (bw ? 8'h02 : 8'h04);
  assign low = (wl == 3'h0) ? 24'hffff : (wl == 3'h2) ? 24'h0 : (wl == 3'h5) ? (bw ? 24'hff : 24'hfff) :
    (wl == 3'h6) ? (bw ? 24'h0 : 24'hf) : 24'hff;
  // Counts cycles since the latest start request.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= 8'h00;
    end else if (write_start_i || read_start_i) begin
      cnt_ff <= 8'h01;
    end else if (cnt_ff != 8'hff) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_done_latency: assert property (write_done_o |-> cnt_ff == nacc + 8'h01)
    else $error("word took the wrong number of accesses");
  a_read_latency: assert property (read_done_o |->
    cnt_ff == nacc + 8'h01 + {4'h0, emp_pkg::RD_LAG}) else $error("read word took the wrong time");
  a_done_single: assert property ((write_done_o || read_done_o) |=> !(write_done_o || read_done_o))
    else $error("done pulse lasted more than one cycle");
  a_read_zero_fill: assert property (read_done_o |=> (read_data_reg_o & low) == 24'h0)
    else $error("read word not top aligned with zero fill");
  a_abs_pins_high: assert property ((mem_strobe_o && memif_control_status_o[6:3] == 4'h0) |->
    (mem_selects_o[0] && mem_addr_lines_o[15])) else $error("select 0 or line 15 low in mode 0");
  a_reserved_refused: assert property ((write_start_i || read_start_i) && (wl == 3'h4 ||
    wl == 3'h7 || memif_control_status_o[6:5] == 2'b10) |=> !(write_done_o || read_done_o) [*8])
    else $error("start with a reserved code was served");
  a_reset_clear: assert property ($rose(arst_n_i) |-> memif_control_status_o == 24'h0)
    else $error("control register not clear after reset");
  a_csr_write: assert property ((csr_we_i && !memif_control_status_o[15]) |=>
    (memif_control_status_o & 24'h030e7f) == ($past(csr_wdata_i) & 24'h030e7f))
    else $error("control write not stored");
  a_soft_clear: assert property (soft_reset_i |=> (memif_control_status_o & 24'h030e7f) == 24'h0)
    else $error("software reset left control bits set");
  a_read_no_drive: assert property (read_start_i |=> !mem_data_oe_o [*4])
    else $error("data bus driven during a read");
endmodule : emp_word_pack_asserts
bind emp_word_pack emp_word_pack_asserts u_chk (.core_clk_i, .arst_n_i, .soft_reset_i, .csr_we_i,
  .csr_wdata_i, .memif_control_status_o, .write_start_i, .read_start_i, .read_data_reg_o,
  .read_done_o, .write_done_o, .mem_addr_lines_o, .mem_selects_o, .mem_data_oe_o, .mem_strobe_o);
`default_nettype wire

// ---- verification/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic soft_reset_i = 1'b0;
  logic csr_we_i = 1'b0;
  logic [23:0] csr_wdata_i = 24'h0;
  logic write_start_i = 1'b0;
  logic read_start_i = 1'b0;
  logic [23:0] write_data_reg_i = 24'h0;
  logic [23:0] delay_base_reg_i = 24'h0;
  logic [23:0] offset_i = 24'h0;
  logic incr_en_i = 1'b1;
  logic [23:0] memif_control_status_o;
  logic [23:0] read_data_reg_o;
  logic read_done_o;
  logic write_done_o;
  logic base_incr_o;
  logic [17:0] mem_addr_lines_o;
  logic [3:0] mem_selects_o;
  logic [7:0] mem_data_o;
  logic mem_data_oe_o;
  logic mem_strobe_o;
  logic [7:0] mem_data_i;
  int fail_count = 0;
  int cmp_count = 0;
  int inc_cnt = 0;
  int cyc;
  int n;
  logic [23:0] m;
  logic [2:0] wls[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  int bits4[6] = '{8, 16, 24, 16, 12, 20};
  int bits8[6] = '{8, 16, 24, 16, 16, 24};
  int acc4[6] = '{2, 4, 6, 4, 3, 5};
  int acc8[6] = '{1, 2, 3, 2, 2, 3};
  logic [23:0] rsv[4] = '{24'h010000, 24'h010006, 24'h000040, 24'h000058};
  // Device under test and the memory on its pins.
  emp_word_pack dut (.core_clk_i, .arst_n_i, .soft_reset_i, .csr_we_i, .csr_wdata_i,
    .memif_control_status_o, .write_start_i, .write_data_reg_i, .read_start_i, .delay_base_reg_i,
    .offset_i, .incr_en_i, .read_data_reg_o, .read_done_o, .write_done_o, .base_incr_o,
    .mem_addr_lines_o, .mem_selects_o, .mem_data_o, .mem_data_oe_o, .mem_strobe_o, .mem_data_i);
  emp_mem_model #(.HOLD(3)) u_mem (.clk_i(core_clk_i), .addr_i(mem_addr_lines_o),
    .wdata_i(mem_data_o), .oe_i(mem_data_oe_o), .strobe_i(mem_strobe_o), .rdata_o(mem_data_i));
  // Clock of 40 ns and a count of base increment requests.
  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) inc_cnt += (base_incr_o === 1'b1);
  ////////////////////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Control writes only ever happen while the block is idle.
  // idle control writes
  task automatic csr_wr(input logic [23:0] v);
    @(posedge core_clk_i);
    csr_we_i <= 1'b1;
    csr_wdata_i <= v;
    @(posedge core_clk_i);
    csr_we_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask : csr_wr
  // One word transfer; cyc ends as the cycle count from start to done, 40 if never done.
  task automatic xfer(input logic wr, input logic [23:0] d);
    inc_cnt = 0;
    @(posedge core_clk_i);
    write_start_i <= wr;
    read_start_i <= !wr;
    write_data_reg_i <= d;
    @(posedge core_clk_i);
    write_start_i <= 1'b0;
    read_start_i <= 1'b0;
    for (cyc = 1; cyc < 40; cyc++) begin
      #1;
      if ((wr ? write_done_o : read_done_o) === 1'b1) break;
      @(posedge core_clk_i);
    end
    repeat (4) @(posedge core_clk_i);
  endtask : xfer
  function automatic logic [23:0] csrv(input logic b, input logic [2:0] w, input logic [3:0] a);
    return {7'h0, w[2], 9'h0, a, w[1:0], b};
  endfunction : csrv
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////////////
  // Main test sequence.
  initial begin
    repeat (20) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk(memif_control_status_o, 24'h0);
    csr_wr(24'hffffff);
    chk(memif_control_status_o, 24'h030e7f);
    @(posedge core_clk_i);
    soft_reset_i <= 1'b1;
    @(posedge core_clk_i);
    soft_reset_i <= 1'b0;
    #1;
    chk(memif_control_status_o, 24'h0);
    $display("test control register done");
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 6; i++) begin
        csr_wr(csrv(b[0], wls[i], 4'h0));
        n = (b == 1) ? acc8[i] : acc4[i];
        m = ~(24'hffffff >> ((b == 1) ? bits8[i] : bits4[i]));
        xfer(1'b1, 24'habcdef);
        chk(24'(cyc), 24'(n + 1));
        chk(24'(inc_cnt), 24'(n));
        chk({16'h0, u_mem.mem[0] & ((b == 1) ? 8'hff : 8'h0f)}, (b == 1) ? 24'hab : 24'h0a);
        xfer(1'b0, 24'h0);
        chk(24'(cyc), 24'(n + 1 + emp_pkg::RD_LAG));
        chk(read_data_reg_o, 24'habcdef & m);
      end
    end
    $display("test formats done");
    delay_base_reg_i <= 24'h3;
    offset_i <= 24'h1;
    csr_wr(csrv(1'b1, 3'h2, 4'h1));
    xfer(1'b1, 24'h123456);
    chk({16'h0, u_mem.mem[8]}, 24'h12);
    offset_i <= 24'h0;
    xfer(1'b1, 24'h789abc);
    delay_base_reg_i <= 24'h2;
    xfer(1'b0, 24'h0);
    chk(read_data_reg_o, 24'h123456);
    $display("test relative done");
    delay_base_reg_i <= 24'h000205;
    csr_wr(csrv(1'b1, 3'h0, 4'h5));
    xfer(1'b1, 24'h5a0000);
    chk({16'h0000, u_mem.mem[5]}, 24'h00005a);
    chk({6'h00, mem_addr_lines_o}, 24'h000005);
    chk({20'h00000, mem_selects_o}, 24'h000000);
    xfer(1'b0, 24'h0);
    chk(read_data_reg_o, 24'h5a0000);
    $display("test dynamic mode done");
    for (int k = 0; k < 4; k++) begin
      csr_wr(rsv[k]);
      xfer((k % 2) == 0, 24'h0);
      chk(24'(cyc), 24'h28);
    end
    $display("test reserved codes done");
    results();
  end
  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge core_clk_i);
    fail_count++;
    results();
  end
endmodule : testbench
`default_nettype wire
